// file: clock_producer_routing_pkg.sv
`default_nettype none
package clock_producer_routing_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int CHAN_COUNT = 28;
   localparam int PROD_COUNT = 8;
   localparam int RATIO_W = 16;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] OFS_BRANCH = 4'h0;
   localparam logic [3:0] OFS_PRODUCER = 4'h4;
   localparam logic [3:0] OFS_RATIO = 4'h8;
   localparam logic [3:0] OFS_SYSTEM = 4'hc;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BCC_PICK_LSB = 8;
   localparam int BCC_ON_BIT = 14;
   localparam int BCC_FREEZE_BIT = 15;
   localparam int PCC_KEEP_BIT = 21;
   localparam int PCC_MODE_BIT = 20;
   localparam int PCC_OE_BIT = 19;
   localparam int PCC_IDLE_BIT = 18;
   localparam int PCC_DUTY_BIT = 17;
   localparam int PCC_ON_BIT = 16;
   localparam int RATIO_LSB = 8;
   localparam int SYS_USER_RST_BIT = 0;
   localparam int SYS_STANDBY_BIT = 1;
   localparam int SYS_RUN_LSB = 8;
   localparam logic [31:0] PCC_STORE_MASK = 32'h003f1f00;
   localparam logic [15:0] RATIO0_MASK = 16'h00ff;

   // ----------------------------------------------------------------
   // Channel, producer and bus response codes
   // ----------------------------------------------------------------
   localparam logic [5:0] CHAN_LOOP_REF = 6'h00;
   localparam logic [5:0] CHAN_WATCHDOG = 6'h01;
   localparam logic [5:0] CHAN_RTC = 6'h02;
   localparam logic [5:0] CHAN_LAST = 6'h1b;
   localparam logic [3:0] PICK_LAST = 4'h7;
   localparam logic [3:0] WATCHDOG_PICK = 4'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Power-reset value of a producer control word.
   function automatic logic [31:0] producer_reset(input logic [2:0] p);
      unique case (p)
         3'h0: producer_reset = 32'h00010600;
         3'h2: producer_reset = 32'h00010302;
         default: producer_reset = {29'h0, p};
      endcase
   endfunction

   // Byte-lane merge of a write into the current word.
   function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      lane_merge = (old_w & ~m) | (new_w & m);
   endfunction

endpackage
`default_nettype wire

// file: axil_reg_slave.sv
`default_nettype none
module axil_reg_slave
   import clock_producer_routing_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [31:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [31:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   output logic wr_en_o,
   output logic [31:0] wr_addr_o,
   output logic [31:0] wr_data_o,
   output logic [3:0] wr_strb_o,
   input wire logic wr_err_i,
   input wire logic [31:0] rd_data_i,
   input wire logic rd_err_i
);

   logic aw_have_reg;
   logic w_have_reg;

   // ----------------------------------------------------------------
   // Write channels
   // ----------------------------------------------------------------
   assign wr_en_o = aw_have_reg && w_have_reg && !bvalid_o;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awready_o <= 1'b1;
         wready_o <= 1'b1;
         bvalid_o <= 1'b0;
         bresp_o <= RESP_OKAY;
         wr_addr_o <= 32'h0;
         wr_data_o <= 32'h0;
         wr_strb_o <= 4'h0;
      end
      else
      begin
         if (awvalid_i && awready_o)
         begin
            wr_addr_o <= awaddr_i;
            aw_have_reg <= 1'b1;
            awready_o <= 1'b0;
         end
         if (wvalid_i && wready_o)
         begin
            wr_data_o <= wdata_i;
            wr_strb_o <= wstrb_i;
            w_have_reg <= 1'b1;
            wready_o <= 1'b0;
         end
         if (wr_en_o)
         begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_o <= 1'b1;
            bresp_o <= wr_err_i ? RESP_SLVERR : RESP_OKAY;
         end
         if (bvalid_o && bready_i)
         begin
            bvalid_o <= 1'b0;
            awready_o <= 1'b1;
            wready_o <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read channels
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         arready_o <= 1'b1;
         rvalid_o <= 1'b0;
         rdata_o <= 32'h0;
         rresp_o <= RESP_OKAY;
      end
      else if (arvalid_i && arready_o)
      begin
         arready_o <= 1'b0;
         rvalid_o <= 1'b1;
         rdata_o <= rd_data_i;
         rresp_o <= rd_err_i ? RESP_SLVERR : RESP_OKAY;
      end
      else if (rvalid_o && rready_i)
      begin
         rvalid_o <= 1'b0;
         arready_o <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// file: producer_divider.sv
`default_nettype none
module producer_divider #(
   parameter int RATIO_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic mode_i,
   input wire logic [RATIO_W-1:0] ratio_i,
   output logic tick_o
);

   logic [31:0] count_reg;
   logic [31:0] limit;
   logic [4:0] shift;

   always_comb
   begin
      shift = (ratio_i >= RATIO_W'(31)) ? 5'd31 : 5'(ratio_i + RATIO_W'(1));
      if (mode_i)
         limit = 32'h1 << shift;
      else if (ratio_i <= RATIO_W'(1))
         limit = 32'h1;
      else
         limit = 32'(ratio_i);
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || !run_i)
      begin
         count_reg <= 32'h0;
         tick_o <= 1'b0;
      end
      else if (count_reg + 32'h1 >= limit)
      begin
         count_reg <= 32'h0;
         tick_o <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + 32'h1;
         tick_o <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// file: clock_producer_routing.sv
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`default_nettype none
module clock_producer_routing
   import clock_producer_routing_pkg::*;
#(
   parameter int CHANS = CHAN_COUNT,
   parameter int PRODS = PROD_COUNT,
   parameter int RW = RATIO_W
) (
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic [31:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [31:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic WATCHDOG_ON_OPT_I,
   input wire logic WATCHDOG_KEEP_OPT_I,
   input wire logic [CHANS-1:0] PERIPH_REQ_I,
   output logic [CHANS-1:0] CHAN_CLK_EN_O,
   output logic [PRODS-1:0] CLK_OUT_PIN_O,
   output logic [PRODS-1:0] PRODUCER_RUN_O
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [3:0] pick_reg [CHANS];
   logic [CHANS-1:0] chan_on_reg;
   logic [CHANS-1:0] freeze_reg;
   logic [31:0] pctl_reg [PRODS];
   logic [RW-1:0] ratio_reg [PRODS];
   logic [5:0] chan_sel_reg;
   logic [2:0] pctl_sel_reg;
   logic [2:0] ratio_sel_reg;
   logic standby_reg;
   logic user_rst_reg;

   logic wr_en;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_err;
   logic [31:0] rd_data;
   logic rd_err;
   logic [PRODS-1:0] tick;
   logic [PRODS-1:0] prod_lock;
   logic [PRODS-1:0] rtc_use;
   logic [PRODS-1:0] prod_req;
   logic [PRODS-1:0] prod_run;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   axil_reg_slave u_slave (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .awaddr_i(S_AXI_AWADDR),
      .awvalid_i(S_AXI_AWVALID),
      .awready_o(S_AXI_AWREADY),
      .wdata_i(S_AXI_WDATA),
      .wstrb_i(S_AXI_WSTRB),
      .wvalid_i(S_AXI_WVALID),
      .wready_o(S_AXI_WREADY),
      .bresp_o(S_AXI_BRESP),
      .bvalid_o(S_AXI_BVALID),
      .bready_i(S_AXI_BREADY),
      .araddr_i(S_AXI_ARADDR),
      .arvalid_i(S_AXI_ARVALID),
      .arready_o(S_AXI_ARREADY),
      .rdata_o(S_AXI_RDATA),
      .rresp_o(S_AXI_RRESP),
      .rvalid_o(S_AXI_RVALID),
      .rready_i(S_AXI_RREADY),
      .wr_en_o(wr_en),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .wr_strb_o(wr_strb),
      .wr_err_i(wr_err),
      .rd_data_i(rd_data),
      .rd_err_i(rd_err)
   );

   // Address decode shared by both directions.
   function automatic logic addr_mapped(input logic [31:0] a);
      addr_mapped = (a[31:4] == 28'h0) && (a[1:0] == 2'h0);
   endfunction

   // ----------------------------------------------------------------
   // Read-back words
   // ----------------------------------------------------------------
   logic [31:0] bcc_word;
   logic [31:0] pcc_word;
   logic [31:0] ratio_word;
   logic [31:0] sys_word;

   always_comb
   begin
      bcc_word = 32'h0;
      bcc_word[5:0] = chan_sel_reg;
      bcc_word[BCC_PICK_LSB +: 4] = pick_reg[chan_sel_reg[4:0]];
      bcc_word[BCC_ON_BIT] = chan_on_reg[chan_sel_reg[4:0]];
      bcc_word[BCC_FREEZE_BIT] = freeze_reg[chan_sel_reg[4:0]];
      pcc_word = pctl_reg[pctl_sel_reg] | {28'h0, 1'b0, pctl_sel_reg};
      ratio_word = {8'h0, ratio_reg[ratio_sel_reg], 5'h0, ratio_sel_reg};
      sys_word = {16'h0, prod_run, 6'h0, standby_reg, 1'b0};
   end

   always_comb
   begin
      rd_err = !addr_mapped(S_AXI_ARADDR);
      unique case (S_AXI_ARADDR[3:0])
         OFS_BRANCH: rd_data = bcc_word;
         OFS_PRODUCER: rd_data = pcc_word;
         OFS_RATIO: rd_data = ratio_word;
         default: rd_data = sys_word;
      endcase
      if (rd_err)
         rd_data = 32'h0;
   end

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   logic [31:0] bcc_new;
   logic [31:0] pcc_new;
   logic [31:0] ratio_new;
   logic bcc_wr;
   logic pcc_wr;
   logic ratio_wr;
   logic sys_wr;
   logic chan_ok;
   logic pick_ok;
   logic pidx_ok;
   logic ridx_ok;

   always_comb
   begin
      wr_err = !addr_mapped(wr_addr);
      bcc_new = lane_merge(bcc_word, wr_data, wr_strb);
      pcc_new = lane_merge(pcc_word, wr_data, wr_strb);
      ratio_new = lane_merge(ratio_word, wr_data, wr_strb);
      bcc_wr = wr_en && !wr_err && (wr_addr[3:0] == OFS_BRANCH);
      pcc_wr = wr_en && !wr_err && (wr_addr[3:0] == OFS_PRODUCER);
      ratio_wr = wr_en && !wr_err && (wr_addr[3:0] == OFS_RATIO);
      sys_wr = wr_en && !wr_err && (wr_addr[3:0] == OFS_SYSTEM) && wr_strb[0];
      chan_ok = bcc_new[5:0] <= CHAN_LAST;
      pick_ok = bcc_new[BCC_PICK_LSB +: 4] <= PICK_LAST;
      pidx_ok = pcc_new[3:0] <= PICK_LAST;
      ridx_ok = ratio_new[3:0] <= PICK_LAST;
   end

   // Selection pointers move on any write with a legal index.
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         chan_sel_reg <= CHAN_LOOP_REF;
         pctl_sel_reg <= 3'h0;
         ratio_sel_reg <= 3'h0;
      end
      else
      begin
         if (bcc_wr && chan_ok)
            chan_sel_reg <= bcc_new[5:0];
         if (pcc_wr && pidx_ok)
            pctl_sel_reg <= pcc_new[2:0];
         if (ratio_wr && ridx_ok)
            ratio_sel_reg <= ratio_new[2:0];
      end
   end

   // ----------------------------------------------------------------
   // System control: standby level and user reset pulse
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         standby_reg <= 1'b0;
         user_rst_reg <= 1'b0;
      end
      else
      begin
         user_rst_reg <= sys_wr && wr_data[SYS_USER_RST_BIT];
         if (sys_wr)
            standby_reg <= wr_data[SYS_STANDBY_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Channel control words
   // ----------------------------------------------------------------
   for (genvar c = 0; c < CHANS; c++)
   begin : g_chan
      localparam logic [5:0] ID = 6'(c);
      logic hit;
      assign hit = bcc_wr && chan_ok && pick_ok && (bcc_new[5:0] == ID);

      always_ff @(posedge CLK_SYS_I)
      begin
         if (!RST_N_I)
         begin
            // Power reset reloads every channel.
            pick_reg[c] <= (ID == CHAN_WATCHDOG) ? WATCHDOG_PICK : 4'h0;
            chan_on_reg[c] <= (ID == CHAN_WATCHDOG) && WATCHDOG_ON_OPT_I;
            freeze_reg[c] <= (ID == CHAN_WATCHDOG) && WATCHDOG_KEEP_OPT_I;
         end
         else if (user_rst_reg)
         begin
            if (ID == CHAN_RTC)
            begin
               if (!freeze_reg[c] && !chan_on_reg[c])
               begin
                  pick_reg[c] <= 4'h0;
                  chan_on_reg[c] <= 1'b0;
               end
            end
            else if (!freeze_reg[c])
            begin
               pick_reg[c] <= (ID == CHAN_WATCHDOG) ? WATCHDOG_PICK : 4'h0;
               chan_on_reg[c] <= (ID == CHAN_WATCHDOG) && WATCHDOG_ON_OPT_I;
            end
         end
         else if (hit && wr_strb[1] && !freeze_reg[c])
         begin
            pick_reg[c] <= bcc_new[BCC_PICK_LSB +: 4];
            chan_on_reg[c] <= bcc_new[BCC_ON_BIT];
            freeze_reg[c] <= bcc_new[BCC_FREEZE_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Producer lock, real-time use and peripheral demand
   // ----------------------------------------------------------------
   always_comb
   begin
      for (int p = 0; p < PRODS; p++)
      begin
         prod_lock[p] = 1'b0;
         prod_req[p] = 1'b0;
         rtc_use[p] = (pick_reg[CHAN_RTC[4:0]] == 4'(p));
         for (int c = 0; c < CHANS; c++)
         begin
            if (pick_reg[c] == 4'(p))
            begin
               prod_lock[p] = prod_lock[p] | (freeze_reg[c] && (p != 0));
               prod_req[p] = prod_req[p] | (chan_on_reg[c] && (!standby_reg || PERIPH_REQ_I[c]));
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Producers
   // ----------------------------------------------------------------
   for (genvar p = 0; p < PRODS; p++)
   begin : g_prod
      localparam logic [3:0] PID = 4'(p);
      localparam logic [RW-1:0] RMASK = (p == 0) ? RW'(RATIO0_MASK) : {RW{1'b1}};
      logic keep;
      logic oe;
      logic spare;
      logic [31:0] rmerge;

      assign keep = pctl_reg[p][PCC_KEEP_BIT];
      assign oe = pctl_reg[p][PCC_OE_BIT];
      assign spare = (p == 0) || !(prod_lock[p] || rtc_use[p]);
      assign rmerge = lane_merge(32'(ratio_reg[p]) << RATIO_LSB, wr_data, wr_strb);

      always_ff @(posedge CLK_SYS_I)
      begin
         if (!RST_N_I)
         begin
            pctl_reg[p] <= producer_reset(3'(p)) & PCC_STORE_MASK;
            ratio_reg[p] <= '0;
         end
         else if (user_rst_reg)
         begin
            if (spare)
            begin
               pctl_reg[p] <= producer_reset(3'(p)) & PCC_STORE_MASK;
               ratio_reg[p] <= '0;
            end
         end
         else
         begin
            if (pcc_wr && pidx_ok && pcc_new[3:0] == PID && !prod_lock[p])
               pctl_reg[p] <= lane_merge(pctl_reg[p], wr_data, wr_strb)
                  & PCC_STORE_MASK;
            if (ratio_wr && ridx_ok && ratio_new[3:0] == PID && !prod_lock[p])
               ratio_reg[p] <= rmerge[RATIO_LSB +: RW] & RMASK;
         end
      end

      // Running: output-enabled producers follow standby keep-alive, others demand.
      always_comb
      begin
         if (!pctl_reg[p][PCC_ON_BIT])
            prod_run[p] = 1'b0;
         else if (oe)
            prod_run[p] = !standby_reg || keep;
         else
            prod_run[p] = prod_req[p];
      end

      producer_divider #(
         .RATIO_W(RW)
      ) u_div (
         .clk_i(CLK_SYS_I),
         .rst_n_i(RST_N_I),
         .run_i(prod_run[p]),
         .mode_i(pctl_reg[p][PCC_MODE_BIT]),
         .ratio_i(ratio_reg[p]),
         .tick_o(tick[p])
      );

      always_ff @(posedge CLK_SYS_I)
      begin
         if (!RST_N_I)
         begin
            CLK_OUT_PIN_O[p] <= 1'b0;
            PRODUCER_RUN_O[p] <= 1'b0;
         end
         else
         begin
            PRODUCER_RUN_O[p] <= prod_run[p];
            if (!oe || !prod_run[p])
               CLK_OUT_PIN_O[p] <= pctl_reg[p][PCC_IDLE_BIT];
            else if (tick[p])
               CLK_OUT_PIN_O[p] <= !CLK_OUT_PIN_O[p];
         end
      end
   end

   // ----------------------------------------------------------------
   // Routed channel clock enables
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         CHAN_CLK_EN_O <= '0;
      else
         for (int c = 0; c < CHANS; c++)
            CHAN_CLK_EN_O[c] <= chan_on_reg[c] && tick[pick_reg[c][2:0]];
   end

endmodule
`default_nettype wire

// file: clock_producer_routing_monitor.sv
`default_nettype none
// ----------------------------------------------------------------
// Bus answer and clock output checks.
// ----------------------------------------------------------------
module clock_producer_routing_monitor
   import clock_producer_routing_pkg::*;
#(
   parameter int CHANS = 28,
   parameter int PRODS = 8
) (
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic [31:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RVALID,
   input wire logic [CHANS-1:0] CHAN_CLK_EN_O,
   input wire logic [PRODS-1:0] CLK_OUT_PIN_O,
   input wire logic [PRODS-1:0] PRODUCER_RUN_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_ar_take;
      S_AXI_ARVALID && S_AXI_ARREADY;
   endsequence
   sequence s_err_r;
      S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0;
   endsequence
   AST_RD_ERR: assert property (
      s_ar_take and S_AXI_ARADDR[31:4] != 28'h0 |=> s_err_r)
      else $error("bad read address not refused");
   AST_RD_OK: assert property (
      s_ar_take and S_AXI_ARADDR[31:4] == 28'h0 && S_AXI_ARADDR[1:0] == 2'h0
      |=> S_AXI_RRESP == RESP_OKAY)
      else $error("mapped read refused");
   AST_RD_ANSWER: assert property (s_ar_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
      else $error("read not answered");
   AST_WR_ANSWER: assert property (
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
      else $error("write not answered");
   AST_READY_HELD: assert property (
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("ready during response");
   AST_RESET_QUIET: assert property (
      $rose(RST_N_I) |-> CHAN_CLK_EN_O == '0 && CLK_OUT_PIN_O == '0 && !S_AXI_RVALID)
      else $error("outputs active after reset");
   AST_PIN_IDLE: assert property (
      !S_AXI_BVALID && !$past(S_AXI_BVALID) && !$past(S_AXI_BVALID, 2)
      |-> (~PRODUCER_RUN_O & ~$past(PRODUCER_RUN_O)
         & (CLK_OUT_PIN_O ^ $past(CLK_OUT_PIN_O))) == '0)
      else $error("stopped pin moved");
   AST_EN_NEEDS_RUN: assert property (
      CHAN_CLK_EN_O != '0
      |-> (PRODUCER_RUN_O | $past(PRODUCER_RUN_O) | $past(PRODUCER_RUN_O, 2)) != '0)
      else $error("channel pulse with no producer running");
endmodule
`default_nettype wire

// file: periph_model.sv
`default_nettype none
// ----------------------------------------------------------------
// Peripheral side: raises requests and counts clock pulses.
// ----------------------------------------------------------------
module periph_model #(
   parameter int CH = 5
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [27:0] en_i,
   input wire logic [27:0] want_i,
   output logic [27:0] req_o,
   output int pulses_o
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk_i)
   begin
      req_o <= want_i;
   end
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         pulses_o <= 0;
      else if (en_i[CH])
         pulses_o <= pulses_o + 1;
   end
endmodule
`default_nettype wire

// file: clock_producer_routing_tb_top.sv
`default_nettype none
// ----------------------------------------------------------------
// Register bus tests of routing, resets, standby and freeze.
// ----------------------------------------------------------------
module clock_producer_routing_tb_top
   import clock_producer_routing_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic [31:0] aw = 32'h0, wd = 32'h0, ar = 32'h0, d, rdd;
   logic [3:0] ws = 4'h0;
   logic [27:0] want = 28'h0, cen, req;
   logic awr, wr_r, bv, arr, rv;
   logic [1:0] br, rr, r;
   logic [7:0] pin, run;
   int pulses, n, fails = 0, checks_done = 0, cyc = 0;
   clock_producer_routing dut_u (.CLK_SYS_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR(aw),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(bre), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
      .WATCHDOG_ON_OPT_I(1'b1), .WATCHDOG_KEEP_OPT_I(1'b0), .PERIPH_REQ_I(req),
      .CHAN_CLK_EN_O(cen), .CLK_OUT_PIN_O(pin), .PRODUCER_RUN_O(run));
   periph_model #(.CH(5)) far_u (.clk_i(clk), .rst_n_i(rst_n), .en_i(cen), .want_i(want),
      .req_o(req), .pulses_o(pulses));
   task automatic close_out();
      if (fails == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
      @(posedge clk);
      aw <= a;
      wd <= v;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
      end
      while (bv !== 1'b1);
      r = br;
      bre <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a);
      @(posedge clk);
      ar <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end
      while (rv !== 1'b1);
      d = rdd;
      r = rr;
      rre <= 1'b0;
   endtask
   task automatic w(input logic [31:0] a, input logic [31:0] v);
      wr(a, v, 4'hf);
      chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
   endtask
   task automatic rc(input logic [31:0] a, input logic [31:0] e);
      rd(a);
      chk("rdata", d, e);
   endtask
   task automatic sc(input logic [31:0] a, input logic [5:0] i, input logic [31:0] e);
      wr(a, {26'h0, i}, 4'h1);
      rc(a, e);
   endtask
   initial
   begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         close_out();
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int c = 0; c < 28; c++)
         sc(32'h0, c[5:0], (c == 1) ? 32'h4201 : c);
      for (int p = 0; p < 8; p++)
         sc(32'h4, p[5:0], (p == 0) ? 32'h10600 : (p == 2) ? 32'h10302 : p);
      for (int p = 0; p < 8; p++)
      begin
         w(32'h0, 32'h4005 | (p << 8));
         rc(32'h0, 32'h4005 | (p << 8));
      end
      w(32'h0, 32'h4805);
      w(32'h0, 32'h411c);
      rc(32'h0, 32'h4705);
      rd(32'h10);
      chk("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      wr(32'h10, 32'h1, 4'hf);
      chk("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      w(32'h0, 32'h4305);
      for (int k = 0; k < 3; k++)
      begin
         w(32'h4, (k == 2) ? 32'h110003 : 32'h10003);
         w(32'h8, (k == 0) ? 32'h103 : 32'h203);
         repeat (4) @(posedge clk);
         n = pulses;
         repeat (40) @(posedge clk);
         chk("pulses", pulses - n, (k == 0) ? 40 : (k == 1) ? 20 : 5);
      end
      rc(32'hc, 32'hc00);
      w(32'hc, 32'h2);
      rc(32'hc, 32'h2);
      want <= 28'h20;
      repeat (4) @(posedge clk);
      rc(32'hc, 32'h802);
      want <= 28'h0;
      w(32'h4, 32'hd0004);
      repeat (3) @(posedge clk);
      chk("pin", {31'h0, pin[4]}, 32'h1);
      rc(32'hc, 32'h2);
      w(32'h4, 32'h2d0004);
      rc(32'hc, 32'h1002);
      chk("run", {24'h0, run}, 32'h10);
      w(32'hc, 32'h0);
      w(32'h0, 32'hc406);
      w(32'h0, 32'h0106);
      rc(32'h0, 32'hc406);
      w(32'h4, 32'h4);
      sc(32'h4, 6'h04, 32'h2d0004);
      w(32'h0, 32'h4302);
      w(32'h0, 32'h4308);
      w(32'h0, 32'h0001);
      w(32'hc, 32'h1);
      repeat (4) @(posedge clk);
      sc(32'h0, 6'h02, 32'h4302);
      sc(32'h0, 6'h08, 32'h0008);
      sc(32'h0, 6'h01, 32'h4201);
      sc(32'h0, 6'h06, 32'hc406);
      sc(32'h4, 6'h04, 32'h2d0004);
      sc(32'h4, 6'h03, 32'h110003);
      w(32'h0, 32'h0302);
      w(32'hc, 32'h1);
      repeat (4) @(posedge clk);
      sc(32'h0, 6'h02, 32'h0002);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      sc(32'h0, 6'h06, 32'h0006);
      sc(32'h4, 6'h04, 32'h0004);
      close_out();
   end
endmodule
bind clock_producer_routing clock_producer_routing_monitor #(.CHANS(CHANS), .PRODS(PRODS)) mon_u (
   .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
   .S_AXI_RVALID(S_AXI_RVALID), .CHAN_CLK_EN_O(CHAN_CLK_EN_O), .CLK_OUT_PIN_O(CLK_OUT_PIN_O),
   .PRODUCER_RUN_O(PRODUCER_RUN_O));
`default_nettype wire
